// [rtl/audio_clock_defs.svh]
// register offsets, field positions and reset values of the audio clock block
`ifndef AUDIO_CLOCK_DEFS_SVH
`define AUDIO_CLOCK_DEFS_SVH
`define ADDR_CPF_LOW 8'h30
`define ADDR_CPF_MID 8'h31
`define ADDR_CPF_HIGH 8'h32
`define ADDR_INC_LOW 8'h34
`define ADDR_INC_MID 8'h35
`define ADDR_INC_HIGH 8'h36
`define ADDR_BIT_DIV 8'h38
`define ADDR_CHAN_DIV 8'h39
`define ADDR_CONTROL 8'h3A
`define ADDR_LOCK_STATUS 8'h3F
`define CTRL_BIT_PHASE 0
`define CTRL_CHAN_PHASE 1
`define CTRL_VREF_SEL 2
`define CTRL_LOOP_OPEN 3
`define REG_RESET 8'h00
`define CPF_HIGH_BITS 2
`define INC_HIGH_BITS 6
`define DIV_BITS 6
`define CORR_STEP 1
`endif

// [rtl/audio_clock_pkg.sv]
// types shared by the audio clock block
package audio_clock_pkg;
  typedef enum logic [1:0] {
    LOOP_OPEN = 2'b00,
    LOOP_TRACK = 2'b01,
    LOOP_LOCKED = 2'b10
  } loop_state_t;
endpackage : audio_clock_pkg

// [rtl/field_locked_audio_clock_gen.sv]
// field-locked audio master clock synthesizer with bit and channel dividers
// Summary of operation
// - master clock synthesized from the crystal reference clock mclk
// - synthesized clock locked to field rate, fixed clock count per field
// - 18-bit clocks-per-field target split over three byte registers
// - 22-bit nominal increment sets synthesizer step, over three bytes
// - bit clock is external master clock divided by 2*(divider+1)
// - channel clock is bit clock divided by 2*divider
// - control bit 3 zero closes field loop, one opens it
// - control bit 2 selects internal or external vertical reference
// - control bit 1 picks bit clock edge that toggles channel clock
// - control bit 0 picks master input edge that toggles bit clock
// - dividers driven only from external master clock input pin
`timescale 1ns/1ps
`default_nettype none
`include "audio_clock_defs.svh"
module field_locked_audio_clock_gen #(
  parameter int INC_WIDTH = 22,
  parameter int CPF_WIDTH = 18,
  parameter int CORR_WIDTH = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic internal_vsync,
  input wire logic external_vsync,
  input wire logic divider_master_clock_in,
  output logic synth_master_clock_out,
  output logic serial_bit_clock,
  output logic channel_select_clock
);

  if (INC_WIDTH != 22 || CPF_WIDTH != 18) begin : g_width_check
    $error("byte map fixes the increment and count widths");
  end
  if (CORR_WIDTH < 2 || CORR_WIDTH > INC_WIDTH) begin : g_corr_check
    $error("correction width out of range");
  end

  // picks the rising or falling edge from a phase bit
  function automatic logic sel_edge(input logic rise, input logic fall,
                                    input logic ph);
    sel_edge = ph ? rise : fall;
  endfunction : sel_edge

  // one-hot register select for an address, bit 9 the status byte
  function automatic logic [9:0] reg_select(input logic [7:0] addr);
    reg_select = 10'h000;
    if (addr == `ADDR_CPF_LOW) begin
      reg_select[0] = 1'b1;
    end else if (addr == `ADDR_CPF_MID) begin
      reg_select[1] = 1'b1;
    end else if (addr == `ADDR_CPF_HIGH) begin
      reg_select[2] = 1'b1;
    end else if (addr == `ADDR_INC_LOW) begin
      reg_select[3] = 1'b1;
    end else if (addr == `ADDR_INC_MID) begin
      reg_select[4] = 1'b1;
    end else if (addr == `ADDR_INC_HIGH) begin
      reg_select[5] = 1'b1;
    end else if (addr == `ADDR_BIT_DIV) begin
      reg_select[6] = 1'b1;
    end else if (addr == `ADDR_CHAN_DIV) begin
      reg_select[7] = 1'b1;
    end else if (addr == `ADDR_CONTROL) begin
      reg_select[8] = 1'b1;
    end else if (addr == `ADDR_LOCK_STATUS) begin
      reg_select[9] = 1'b1;
    end
  endfunction : reg_select

  logic [7:0] cpf_low;
  logic [7:0] cpf_mid;
  logic [`CPF_HIGH_BITS-1:0] cpf_high;
  logic [7:0] inc_low;
  logic [7:0] inc_mid;
  logic [`INC_HIGH_BITS-1:0] inc_high;
  logic [`DIV_BITS-1:0] bit_clock_divider;
  logic [`DIV_BITS-1:0] channel_clock_divider;
  logic [3:0] control;
  logic [CPF_WIDTH-1:0] clocks_per_field;
  logic [INC_WIDTH-1:0] nominal_increment;
  logic loop_open_select;
  logic vertical_ref_select;
  logic channel_clock_phase;
  logic bit_clock_phase;

  assign clocks_per_field = {cpf_high, cpf_mid, cpf_low};
  assign nominal_increment = {inc_high, inc_mid, inc_low};
  assign bit_clock_phase = control[`CTRL_BIT_PHASE];
  assign channel_clock_phase = control[`CTRL_CHAN_PHASE];
  assign vertical_ref_select = control[`CTRL_VREF_SEL];
  assign loop_open_select = control[`CTRL_LOOP_OPEN];
  logic [9:0] reg_sel;
  assign reg_sel = reg_select(reg_addr);

  // register writes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cpf_low <= `REG_RESET;
      cpf_mid <= `REG_RESET;
      cpf_high <= '0;
      inc_low <= `REG_RESET;
      inc_mid <= `REG_RESET;
      inc_high <= '0;
      bit_clock_divider <= '0;
      channel_clock_divider <= '0;
      control <= '0;
    end else if (reg_wr) begin
      if (reg_sel[0]) begin
        cpf_low <= reg_wdata;
      end else if (reg_sel[1]) begin
        cpf_mid <= reg_wdata;
      end else if (reg_sel[2]) begin
        cpf_high <= reg_wdata[`CPF_HIGH_BITS-1:0];
      end else if (reg_sel[3]) begin
        inc_low <= reg_wdata;
      end else if (reg_sel[4]) begin
        inc_mid <= reg_wdata;
      end else if (reg_sel[5]) begin
        inc_high <= reg_wdata[`INC_HIGH_BITS-1:0];
      end else if (reg_sel[6]) begin
        bit_clock_divider <= reg_wdata[`DIV_BITS-1:0];
      end else if (reg_sel[7]) begin
        channel_clock_divider <= reg_wdata[`DIV_BITS-1:0];
      end else if (reg_sel[8]) begin
        control[`CTRL_LOOP_OPEN] <= reg_wdata[`CTRL_LOOP_OPEN];
        control[`CTRL_VREF_SEL] <= reg_wdata[`CTRL_VREF_SEL];
        control[`CTRL_CHAN_PHASE] <= reg_wdata[`CTRL_CHAN_PHASE];
        control[`CTRL_BIT_PHASE] <= reg_wdata[`CTRL_BIT_PHASE];
      end
    end
  end

  audio_clock_pkg::loop_state_t loop_state;
  logic signed [CORR_WIDTH-1:0] correction;
  logic [7:0] status_byte;
  assign status_byte = {4'h0, correction[CORR_WIDTH-1], 1'b0, loop_state};

  // register reads, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= `REG_RESET;
    end else if (reg_rd) begin
      if (reg_sel[0]) begin
        reg_rdata <= cpf_low;
      end else if (reg_sel[1]) begin
        reg_rdata <= cpf_mid;
      end else if (reg_sel[2]) begin
        reg_rdata <= {6'h00, cpf_high};
      end else if (reg_sel[3]) begin
        reg_rdata <= inc_low;
      end else if (reg_sel[4]) begin
        reg_rdata <= inc_mid;
      end else if (reg_sel[5]) begin
        reg_rdata <= {2'h0, inc_high};
      end else if (reg_sel[6]) begin
        reg_rdata <= {2'h0, bit_clock_divider};
      end else if (reg_sel[7]) begin
        reg_rdata <= {2'h0, channel_clock_divider};
      end else if (reg_sel[8]) begin
        reg_rdata <= {4'h0, control};
      end else if (reg_sel[9]) begin
        reg_rdata <= status_byte;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // pin synchronisers
  logic [1:0] ext_v_sync;
  logic [1:0] mclk_in_sync;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ext_v_sync <= 2'h0;
      mclk_in_sync <= 2'h0;
    end else begin
      ext_v_sync <= {ext_v_sync[0], external_vsync};
      mclk_in_sync <= {mclk_in_sync[0], divider_master_clock_in};
    end
  end

  // vertical reference edge
  logic vref_prev;
  logic vref_now;
  logic field_start;
  assign vref_now = vertical_ref_select ? ext_v_sync[1] : internal_vsync;
  assign field_start = vref_now && !vref_prev;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      vref_prev <= 1'b0;
    end else begin
      vref_prev <= vref_now;
    end
  end

  // phase accumulator clocked by the crystal reference
  logic [INC_WIDTH:0] phase_acc;
  logic [INC_WIDTH:0] next_phase_acc;
  logic [INC_WIDTH:0] step;
  assign step = {1'b0, nominal_increment}
              + {{(INC_WIDTH+1-CORR_WIDTH){correction[CORR_WIDTH-1]}},
                 correction};
  assign next_phase_acc = phase_acc + step;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phase_acc <= '0;
      synth_master_clock_out <= 1'b0;
    end else begin
      phase_acc <= next_phase_acc;
      synth_master_clock_out <= next_phase_acc[INC_WIDTH];
    end
  end

  // synthesized clocks counted per field, correction nudged once a field
  logic [CPF_WIDTH-1:0] field_count;
  logic synth_rise;
  assign synth_rise = next_phase_acc[INC_WIDTH] && !synth_master_clock_out;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      field_count <= '0;
      correction <= '0;
      loop_state <= audio_clock_pkg::LOOP_OPEN;
    end else if (loop_open_select) begin
      field_count <= '0;
      correction <= '0;
      loop_state <= audio_clock_pkg::LOOP_OPEN;
    end else if (field_start) begin
      field_count <= '0;
      if (field_count < clocks_per_field) begin
        correction <= correction + CORR_WIDTH'(`CORR_STEP);
        loop_state <= audio_clock_pkg::LOOP_TRACK;
      end else if (field_count > clocks_per_field) begin
        correction <= correction - CORR_WIDTH'(`CORR_STEP);
        loop_state <= audio_clock_pkg::LOOP_TRACK;
      end else begin
        loop_state <= audio_clock_pkg::LOOP_LOCKED;
      end
    end else if (synth_rise && field_count != '1) begin
      field_count <= field_count + CPF_WIDTH'(1);
    end
  end

  // bit clock divider on the returned master clock
  logic mclk_in_prev;
  logic mclk_in_edge;
  logic [`DIV_BITS-1:0] bit_count;
  assign mclk_in_edge = sel_edge(mclk_in_sync[1] && !mclk_in_prev,
                                 !mclk_in_sync[1] && mclk_in_prev,
                                 bit_clock_phase);
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mclk_in_prev <= 1'b0;
      bit_count <= '0;
      serial_bit_clock <= 1'b0;
    end else begin
      mclk_in_prev <= mclk_in_sync[1];
      if (mclk_in_edge) begin
        if (bit_count >= bit_clock_divider) begin
          bit_count <= '0;
          serial_bit_clock <= !serial_bit_clock;
        end else begin
          bit_count <= bit_count + `DIV_BITS'(1);
        end
      end
    end
  end

  // channel clock divider on the bit clock
  logic bit_prev;
  logic bit_edge;
  logic [`DIV_BITS-1:0] chan_count;
  assign bit_edge = sel_edge(serial_bit_clock && !bit_prev,
                             !serial_bit_clock && bit_prev,
                             channel_clock_phase);
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bit_prev <= 1'b0;
      chan_count <= '0;
      channel_select_clock <= 1'b0;
    end else begin
      bit_prev <= serial_bit_clock;
      if (bit_edge && channel_clock_divider != '0) begin
        if (chan_count >= channel_clock_divider - `DIV_BITS'(1)) begin
          chan_count <= '0;
          channel_select_clock <= !channel_select_clock;
        end else begin
          chan_count <= chan_count + `DIV_BITS'(1);
        end
      end
    end
  end

endmodule : field_locked_audio_clock_gen
`default_nettype wire

// [dv/audio_clock_checker.sv]
// checker and bind for the audio clock block
`timescale 1ns/1ps
`default_nettype none
module audio_clock_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic divider_master_clock_in,
  input wire logic synth_master_clock_out,
  input wire logic serial_bit_clock,
  input wire logic channel_select_clock
);
  logic [3:0] ctl;
  always_ff @(posedge mclk)
    if (!nrst) ctl <= 4'h0;
    else if (reg_wr && reg_addr == 8'h3A) ctl <= reg_wdata[3:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=>
    !synth_master_clock_out && !serial_bit_clock && !channel_select_clock)
    else $error("clock out after reset");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h33 |=>
    reg_rdata == 8'h00) else $error("unmapped read");
  a_cpf_high: assert property (reg_rd && reg_addr == 8'h32 |=>
    reg_rdata[7:2] == 6'h0) else $error("cpf high bits");
  a_inc_high: assert property (reg_rd && reg_addr == 8'h36 |=>
    reg_rdata[7:6] == 2'h0) else $error("inc high bits");
  a_div_high: assert property (reg_rd && reg_addr[7:1] == 7'h1C
    |=> reg_rdata[7:6] == 2'h0) else $error("div high bits");
  a_ctl_high: assert property (reg_rd && reg_addr == 8'h3A |=>
    reg_rdata[7:4] == 4'h0) else $error("ctl high bits");
  a_open_status: assert property (reg_rd && reg_addr == 8'h3F &&
    ctl[3] && $past(ctl[3], 3) |=> {reg_rdata[3], reg_rdata[1:0]} == 3'h0)
    else $error("open loop status");
  a_bit_edge: assert property ($changed(serial_bit_clock) &&
    ctl == $past(ctl, 6) |-> $past(divider_master_clock_in, 3) == ctl[0]
    && $past(divider_master_clock_in, 5) != ctl[0]) else $error("bit edge");
  a_chan_edge: assert property ($changed(channel_select_clock) &&
    ctl == $past(ctl, 6) |-> $past(serial_bit_clock) == ctl[1] &&
    $past(serial_bit_clock, 3) != ctl[1]) else $error("chan edge");
  c_bit: cover property ($changed(serial_bit_clock));
  c_chan: cover property ($changed(channel_select_clock));
  c_stat: cover property (reg_rd && reg_addr == 8'h3F);
endmodule : audio_clock_checker
bind field_locked_audio_clock_gen audio_clock_checker u_chk (.mclk, .nrst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .divider_master_clock_in, .synth_master_clock_out, .serial_bit_clock,
  .channel_select_clock);
`default_nettype wire

// [dv/audio_sink_model.sv]
// far side: loops master clock back, counts bit clocks per channel half
`timescale 1ns/1ps
`default_nettype none
module audio_sink_model (
  input wire logic mclk,
  input wire logic master_out,
  input wire logic bit_clk,
  input wire logic chan_clk,
  output logic master_in,
  output logic [7:0] bits_per_half
);
  logic [7:0] cnt;
  logic bit_q, chan_q;
  assign master_in = master_out;
  always @(posedge mclk) begin
    bit_q <= bit_clk;
    chan_q <= chan_clk;
    if (chan_clk != chan_q) begin
      bits_per_half <= cnt;
      cnt <= 8'h00;
    end else if (bit_clk && !bit_q) cnt <= cnt + 8'h01;
  end
endmodule : audio_sink_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the audio clock block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk, nrst, reg_wr, reg_rd, ivs, evs, synth, mxin, sbc, lrc, p;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, bph;
  int bad_count = 0, checks_done = 0, n;
  logic [7:0] adr [9] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36,
    8'h38, 8'h39, 8'h3A};
  logic [7:0] msk [9] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h3F,
    8'h3F, 8'h3F, 8'h0F};
  field_locked_audio_clock_gen dut (.mclk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .internal_vsync(ivs),
    .external_vsync(evs), .divider_master_clock_in(mxin),
    .synth_master_clock_out(synth), .serial_bit_clock(sbc),
    .channel_select_clock(lrc));
  audio_sink_model far (.mclk, .master_out(synth), .bit_clk(sbc),
    .chan_clk(lrc), .master_in(mxin), .bits_per_half(bph));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic cmp(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, d);
    @(negedge mclk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    @(negedge mclk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    cmp(reg_rdata, exp);
  endtask : rd
  task automatic half(input logic ch, input logic [7:0] exp);
    logic s;
    int k;
    for (int i = 0; i < 3; i++) begin
      s = ch ? lrc : sbc;
      k = 0;
      while ((ch ? lrc : sbc) === s && k < 500) begin
        @(negedge mclk);
        k++;
      end
    end
    cmp(8'(k), exp);
  endtask : half
  task automatic fields(input logic ext);
    repeat (4) begin
      @(negedge mclk);
      {ivs, evs} = {!ext, ext};
      repeat (10) @(negedge mclk);
      {ivs, evs} = 2'h0;
      repeat (390) @(negedge mclk);
    end
  endtask : fields
  task automatic final_report();
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
  initial begin
    {nrst, reg_wr, reg_rd, ivs, evs, reg_addr, reg_wdata} = 21'h0;
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    foreach (adr[i]) rd(adr[i], 8'h00);
    foreach (adr[i]) wr(adr[i], 8'hFF);
    foreach (adr[i]) rd(adr[i], msk[i]);
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h00);
    foreach (adr[i]) wr(adr[i], 8'h00);
    wr(8'h36, 8'h10);
    wr(8'h38, 8'h01);
    wr(8'h39, 8'h02);
    wr(8'h3A, 8'h08);
    rd(8'h3F, 8'h00);
    n = 0;
    repeat (800) begin
      p = synth;
      @(negedge mclk);
      if (synth && !p) n++;
    end
    cmp(8'(n), 8'h64);
    for (int ph = 0; ph < 4; ph++) begin
      wr(8'h3A, 8'h08 | 8'(ph));
      half(1'b0, 8'h10);
      half(1'b1, 8'h40);
      cmp(bph, 8'h02);
    end
    wr(8'h30, 8'h3C);
    wr(8'h3A, 8'h00);
    fields(1'b0);
    rd(8'h3F, 8'h01);
    wr(8'h3A, 8'h08);
    wr(8'h30, 8'h28);
    wr(8'h3A, 8'h04);
    fields(1'b1);
    rd(8'h3F, 8'h09);
    final_report();
  end
endmodule : testbench
`default_nettype wire
